/* File: common/usart_baud_map.vh */
// Register map, field positions and reset values of the baud and clock block
`ifndef USART_BAUD_MAP_VH
`define USART_BAUD_MAP_VH

// ****************************************************************
// Register byte offsets on the Wishbone bus
// ****************************************************************
`define LOW_OFFSET       8'h00
`define HIGH_OFFSET      8'h04
`define CTRL_OFFSET      8'h08
`define STATUS_OFFSET    8'h0C

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_WIDTH       5
`define CTRL_EDGE_BIT    0
`define CTRL_DOUBLE_BIT  1
`define CTRL_SYNC_BIT    2
`define CTRL_LEGACY_BIT  3
`define CTRL_DRIVE_BIT   4
`define CTRL_RESET       5'h00

// ****************************************************************
// Divisor layout and reset values
// ****************************************************************
`define DIV_WIDTH        12
`define DIV_HIGH_WIDTH   4
`define DIV_LOW_WIDTH    8
`define DIV_RESET        12'h000
`define DIV_HIGH_RESET   4'h0
`define DIV_LOW_RESET    8'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define STAT_COUNT_LSB   0
`define STAT_CLOCK_BIT   12
`define STAT_PHASE_LSB   13

// ****************************************************************
// Oversampling phase limits, normal and double speed
// ****************************************************************
`define PHASE_WIDTH      4
`define PHASE_RESET      4'h0
`define PHASE_LAST_NORM  4'hF
`define PHASE_LAST_DBL   4'h7

`endif

/* File: hdl/baud_prescaler.v */
// Down-counting baud prescaler with immediate reload
`timescale 1ns/100ps

module baud_prescaler #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Reload request and value
  input  wire             reload_i,
  input  wire [WIDTH-1:0] load_value_i,
  input  wire [WIDTH-1:0] divisor_i,
  // Tick and count
  output wire             tick_o,
  output wire [WIDTH-1:0] count_o
);

  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;
  reg             tick_q;
  reg             tick_d;

  // ****************************************************************
  // Count from the divisor down to zero, then reload
  // ****************************************************************
  always @* begin
    tick_d  = 1'b0;
    count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    if (reload_i) begin
      count_d = load_value_i;
    end else if (count_q == {WIDTH{1'b0}}) begin
      count_d = divisor_i;
      tick_d  = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= {WIDTH{1'b0}};
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign tick_o  = tick_q;
  assign count_o = count_q;

endmodule

/* File: hdl/usart_baud_clock.v */
// Baud divisor registers, prescaler and serial clock edge control
//
// Notes on behaviour
// - Edge select picks launch and sample clock edges.
// - Divisor is twelve bits, positions eleven to zero.
// - High register four upper bits, low eight lower.
// - Low register write reloads prescaler at once.
// - Legacy mode removes the high divisor register.
// - Double speed divides by eight, async only.
// - Mode select: clear async, set synchronous.
`timescale 1ns/100ps
`include "usart_baud_map.vh"

module usart_baud_clock (
  // Clock and reset
  input  wire        CLOCK_I,
  input  wire        RST_I,
  // Wishbone slave
  input  wire        CYC_I,
  input  wire        STB_I,
  input  wire        WE_I,
  input  wire [7:0]  ADR_I,
  input  wire [3:0]  SEL_I,
  input  wire [31:0] DAT_I,
  output wire [31:0] DAT_O,
  output wire        ACK_O,
  output wire        ERR_O,
  // Shared serial clock pin
  input  wire        SYNC_SERIAL_CLOCK_I,
  output wire        SYNC_SERIAL_CLOCK_O,
  output wire        SYNC_SERIAL_CLOCK_OE_O,
  // Timing enables to the transmitter and receiver
  output wire        BAUD_TICK_O,
  output wire        TX_SHIFT_O,
  output wire        RX_SAMPLE_O,
  // Mode seen by the datapaths
  output wire        SYNC_MODE_O,
  output wire        DOUBLE_SPEED_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [`DIV_LOW_WIDTH-1:0]  div_low_q;
  reg  [`DIV_HIGH_WIDTH-1:0] div_high_q;
  reg  [`CTRL_WIDTH-1:0]     ctrl_q;
  reg                        ack_q;
  reg                        err_q;
  reg  [31:0]                dat_q;
  reg  [31:0]                rd_data;
  reg                        addr_hit;
  reg  [`PHASE_WIDTH-1:0]    phase_q;
  reg  [`PHASE_WIDTH-1:0]    phase_last;
  reg                        bit_pulse;
  reg                        clk_meta_q;
  reg                        clk_sync_q;
  reg                        clk_prev_q;
  reg                        clk_level_q;
  reg                        xck_q;
  reg                        xck_oe_q;
  reg                        tx_shift_q;
  reg                        rx_sample_q;
  reg                        tx_shift_d;
  reg                        rx_sample_d;

  wire                       request;
  wire                       answered;
  wire                       write_now;
  wire                       low_wr;
  wire                       high_wr;
  wire                       ctrl_wr;
  wire                       edge_sel;
  wire                       double_speed;
  wire                       sync_mode;
  wire                       legacy_mode;
  wire                       drive_clock;
  wire [`DIV_HIGH_WIDTH-1:0] high_eff;
  wire [`DIV_WIDTH-1:0]      divisor;
  wire [`DIV_WIDTH-1:0]      reload_value;
  wire                       tick;
  wire [`DIV_WIDTH-1:0]      count;
  wire                       rise_int;
  wire                       fall_int;
  wire                       ext_agree;
  wire                       rise_ext;
  wire                       fall_ext;
  wire                       clk_rise;
  wire                       clk_fall;
  wire                       clk_level;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  assign edge_sel     = ctrl_q[`CTRL_EDGE_BIT];
  assign double_speed = ctrl_q[`CTRL_DOUBLE_BIT];
  assign sync_mode    = ctrl_q[`CTRL_SYNC_BIT];
  assign legacy_mode  = ctrl_q[`CTRL_LEGACY_BIT];
  assign drive_clock  = ctrl_q[`CTRL_DRIVE_BIT];

  // ****************************************************************
  // Wishbone handshake
  // ****************************************************************
  assign request   = CYC_I & STB_I;
  assign answered  = ack_q | err_q;
  // Writes land on the edge where the master sees ack
  assign write_now = request & WE_I & SEL_I[0] & ack_q;

  always @* begin
    addr_hit = 1'b0;
    rd_data  = 32'h0000_0000;
    if (ADR_I == `LOW_OFFSET) begin
      addr_hit = 1'b1;
      rd_data  = {24'h00_0000, div_low_q};
    end else if (ADR_I == `HIGH_OFFSET) begin
      addr_hit = 1'b1;
      rd_data  = {28'h000_0000, high_eff};
    end else if (ADR_I == `CTRL_OFFSET) begin
      addr_hit = 1'b1;
      rd_data  = {27'h000_0000, ctrl_q};
    end else if (ADR_I == `STATUS_OFFSET) begin
      addr_hit = 1'b1;
      rd_data  = {15'h0000, phase_q, clk_level, count};
    end
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= request & ~answered & addr_hit;
      err_q <= request & ~answered & ~addr_hit;
      if (request & ~answered & ~WE_I) begin
        dat_q <= rd_data;
      end else if (~request) begin
        dat_q <= 32'h0000_0000;
      end
    end
  end

  assign ACK_O = ack_q;
  assign ERR_O = err_q;
  assign DAT_O = dat_q;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  assign low_wr  = write_now & (ADR_I == `LOW_OFFSET);
  // Legacy mode has no high register, so its writes are dropped
  assign high_wr = write_now & (ADR_I == `HIGH_OFFSET) & ~legacy_mode;
  assign ctrl_wr = write_now & (ADR_I == `CTRL_OFFSET);

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      div_low_q  <= `DIV_LOW_RESET;
      div_high_q <= `DIV_HIGH_RESET;
      ctrl_q     <= `CTRL_RESET;
    end else begin
      if (low_wr) begin
        div_low_q <= DAT_I[`DIV_LOW_WIDTH-1:0];
      end
      if (high_wr) begin
        // Upper nibble is reserved and not stored
        div_high_q <= DAT_I[`DIV_HIGH_WIDTH-1:0];
      end
      if (ctrl_wr) begin
        ctrl_q <= DAT_I[`CTRL_WIDTH-1:0];
      end
    end
  end

  // ****************************************************************
  // Divisor assembly
  // ****************************************************************
  assign high_eff     = legacy_mode ? `DIV_HIGH_RESET : div_high_q;
  assign divisor      = {high_eff, div_low_q};
  assign reload_value = {high_eff, DAT_I[`DIV_LOW_WIDTH-1:0]};

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  baud_prescaler #(
    .WIDTH (`DIV_WIDTH)
  ) u_prescaler (
    .clk_i        (CLOCK_I),
    .rst_i        (RST_I),
    .reload_i     (low_wr),
    .load_value_i (reload_value),
    .divisor_i    (divisor),
    .tick_o       (tick),
    .count_o      (count)
  );

  // ****************************************************************
  // Asynchronous bit rate: sixteen or eight ticks per bit
  // ****************************************************************
  always @* begin
    phase_last = `PHASE_LAST_NORM;
    if (double_speed) begin
      phase_last = `PHASE_LAST_DBL;
    end
    bit_pulse = tick & ~sync_mode & (phase_q == phase_last);
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      phase_q <= `PHASE_RESET;
    end else if (sync_mode | low_wr) begin
      // Double speed has no effect on the synchronous rate
      phase_q <= `PHASE_RESET;
    end else if (tick) begin
      if (phase_q >= phase_last) begin
        phase_q <= `PHASE_RESET;
      end else begin
        phase_q <= phase_q + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Shared serial clock: driven from the prescaler or taken in
  // ****************************************************************
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      xck_q    <= 1'b0;
      xck_oe_q <= 1'b0;
    end else begin
      xck_oe_q <= sync_mode & drive_clock;
      if (~(sync_mode & drive_clock)) begin
        xck_q <= 1'b0;
      end else if (tick) begin
        xck_q <= ~xck_q;
      end
    end
  end

  assign rise_int = sync_mode & drive_clock & tick & ~xck_q;
  assign fall_int = sync_mode & drive_clock & tick & xck_q;

  // Three stage input capture; a level counts once stages two and three agree
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      clk_meta_q  <= 1'b0;
      clk_sync_q  <= 1'b0;
      clk_prev_q  <= 1'b0;
      clk_level_q <= 1'b0;
    end else begin
      clk_meta_q <= SYNC_SERIAL_CLOCK_I;
      clk_sync_q <= clk_meta_q;
      clk_prev_q <= clk_sync_q;
      if (ext_agree) begin
        clk_level_q <= clk_prev_q;
      end
    end
  end

  assign ext_agree = sync_mode & ~drive_clock & (clk_sync_q == clk_prev_q);
  assign rise_ext  = ext_agree & clk_prev_q & ~clk_level_q;
  assign fall_ext  = ext_agree & ~clk_prev_q & clk_level_q;
  assign clk_rise  = rise_int | rise_ext;
  assign clk_fall  = fall_int | fall_ext;
  assign clk_level = drive_clock ? xck_q : clk_level_q;

  // ****************************************************************
  // Launch and sample enables
  // ****************************************************************
  always @* begin
    if (sync_mode) begin
      if (edge_sel) begin
        tx_shift_d  = clk_fall;
        rx_sample_d = clk_rise;
      end else begin
        tx_shift_d  = clk_rise;
        rx_sample_d = clk_fall;
      end
    end else begin
      // Edge select is ignored in asynchronous operation
      tx_shift_d  = bit_pulse;
      rx_sample_d = tick;
    end
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      tx_shift_q  <= 1'b0;
      rx_sample_q <= 1'b0;
    end else begin
      tx_shift_q  <= tx_shift_d;
      rx_sample_q <= rx_sample_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign SYNC_SERIAL_CLOCK_O    = xck_q;
  assign SYNC_SERIAL_CLOCK_OE_O = xck_oe_q;
  assign BAUD_TICK_O            = tick;
  assign TX_SHIFT_O             = tx_shift_q;
  assign RX_SAMPLE_O            = rx_sample_q;
  assign SYNC_MODE_O            = sync_mode;
  assign DOUBLE_SPEED_O         = double_speed;

endmodule

/* File: verification/usart_baud_clock_monitor.sv */
// Checker for the baud divisor and serial clock block
`timescale 1ns/100ps
module usart_baud_clock_monitor (
  // Clock, reset and bus
  input logic        CLOCK_I,
  input logic        RST_I,
  input logic        CYC_I,
  input logic        STB_I,
  input logic        WE_I,
  input logic [7:0]  ADR_I,
  input logic [3:0]  SEL_I,
  input logic [31:0] DAT_I,
  input logic        ACK_O,
  input logic        ERR_O,
  // Serial clock and timing outputs
  input logic        SYNC_SERIAL_CLOCK_O,
  input logic        SYNC_SERIAL_CLOCK_OE_O,
  input logic        BAUD_TICK_O,
  input logic        TX_SHIFT_O,
  input logic        RX_SAMPLE_O,
  input logic        SYNC_MODE_O,
  input logic        DOUBLE_SPEED_O
);
  logic [3:0]  ctl_q;
  logic [3:0]  hi_q;
  logic [7:0]  lo_q;
  logic [11:0] cnt_q;
  logic [11:0] div;
  logic        wr;
  logic        ld;
  assign wr  = ACK_O && WE_I && SEL_I[0];
  assign ld  = wr && ADR_I == 8'h00;
  assign div = {ctl_q[3] ? 4'h0 : hi_q, lo_q};
  // Mirror of the prescaler count
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      ctl_q <= 4'h0;
      hi_q  <= 4'h0;
      lo_q  <= 8'h00;
      cnt_q <= 12'h000;
    end else begin
      if (wr && ADR_I == 8'h08) ctl_q <= DAT_I[3:0];
      if (wr && ADR_I == 8'h04 && !ctl_q[3]) hi_q <= DAT_I[3:0];
      if (ld) lo_q <= DAT_I[7:0];
      if (ld) cnt_q <= {div[11:8], DAT_I[7:0]};
      else if (cnt_q == 12'h000) cnt_q <= div;
      else cnt_q <= cnt_q - 12'h001;
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_req; CYC_I && STB_I && !ACK_O && !ERR_O; endsequence
  sequence s_ctl; wr && ADR_I == 8'h08; endsequence
  sequence s_rise;
    SYNC_SERIAL_CLOCK_OE_O && SYNC_MODE_O && $rose(SYNC_SERIAL_CLOCK_O);
  endsequence
  sequence s_fall;
    SYNC_SERIAL_CLOCK_OE_O && SYNC_MODE_O && $fell(SYNC_SERIAL_CLOCK_O);
  endsequence
  property p_answer; s_req |=> ACK_O != ERR_O; endproperty
  property p_unmapped;
    s_req ##0 (ADR_I[1:0] != 2'b00 || ADR_I > 8'h0C) |=> ERR_O;
  endproperty
  property p_tick;
    !RST_I && cnt_q == 12'h000 && !ld |=> BAUD_TICK_O;
  endproperty
  property p_quiet; cnt_q != 12'h000 && !ld |=> !BAUD_TICK_O; endproperty
  property p_mode; s_ctl |=> SYNC_MODE_O == $past(DAT_I[2]); endproperty
  property p_double; s_ctl |=> DOUBLE_SPEED_O == $past(DAT_I[1]); endproperty
  property p_over; BAUD_TICK_O && !SYNC_MODE_O |=> RX_SAMPLE_O; endproperty
  // Pulse and clock toggle leave the same edge, with the old edge select
  property p_launch;
    s_rise |-> ($past(ctl_q[0]) ? RX_SAMPLE_O : TX_SHIFT_O);
  endproperty
  property p_catch;
    s_fall |-> ($past(ctl_q[0]) ? TX_SHIFT_O : RX_SAMPLE_O);
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered by exactly one strobe");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");
  a_tick: assert property (p_tick)
    else $error("tick missing at count zero");
  a_quiet: assert property (p_quiet)
    else $error("tick while count not zero");
  a_mode: assert property (p_mode)
    else $error("mode output differs from written bit");
  a_double: assert property (p_double)
    else $error("double speed output differs from written bit");
  a_over: assert property (p_over)
    else $error("async sample pulse missing after tick");
  a_launch: assert property (p_launch)
    else $error("wrong pulse after rising serial clock");
  a_catch: assert property (p_catch)
    else $error("wrong pulse after falling serial clock");
endmodule

/* File: verification/serial_clock_partner.sv */
// External serial clock source for the synchronous slave case
`timescale 1ns/100ps
module serial_clock_partner #(
  parameter int HALF = 12
) (
  input  logic clk_i,
  input  logic en_i,
  output logic sck_o
);
  int cnt;
  initial begin
    sck_o = 1'b0;
    cnt   = 0;
  end
  // Runs only while en_i is high, stands still at its level otherwise
  always @(posedge clk_i) begin
    if (en_i) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) sck_o <= ~sck_o;
    end
  end
endmodule

/* File: verification/usart_baud_clock_test.sv */
// Self-checking bench for the baud divisor and serial clock block
`timescale 1ns/100ps
module usart_baud_clock_test;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] r;
  logic        x;
  logic        pen;
  wire  [31:0] rdat;
  wire         ack, err, sck, sck_oe, tick, txs, rxs, smode, dbl, psck, pin;
  int          error_cnt;
  int          tests_run;
  int          n;
  assign pin = sck_oe ? sck : psck;
  usart_baud_clock uut (
    .CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack),
    .ERR_O(err), .SYNC_SERIAL_CLOCK_I(pin), .SYNC_SERIAL_CLOCK_O(sck),
    .SYNC_SERIAL_CLOCK_OE_O(sck_oe), .BAUD_TICK_O(tick), .TX_SHIFT_O(txs),
    .RX_SAMPLE_O(rxs), .SYNC_MODE_O(smode), .DOUBLE_SPEED_O(dbl)
  );
  serial_clock_partner #(.HALF(12)) peer (
    .clk_i(clk), .en_i(pen), .sck_o(psck)
  );
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tmo;
    error_cnt++;
    give_verdict;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
    if (i >= 20) tmo;
    r = rdat;
    x = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic logic pk(input int s);
    return s == 0 ? tick : (s == 1 ? txs : rxs);
  endfunction
  // Cycles between two successive pulses of one timing output
  task per(input int s);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pk(s) !== 1'b1 && i < 9000);
    if (i >= 9000) tmo;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pk(s) !== 1'b1 && n < 9000);
    if (n >= 9000) tmo;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    for (int a = 0; a < 12; a += 4) begin
      wb(1'b0, a[7:0], 32'h0000_0000);
      chk(r, 32'h0000_0000);
    end
    wb(1'b1, 8'h04, 32'h0000_000A);
    wb(1'b1, 8'h00, 32'h0000_005C);
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk(r, 32'h0000_005C);
    wb(1'b0, 8'h04, 32'h0000_0000);
    chk(r, 32'h0000_000A);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk(x, 1'b1);
  endtask
  task t_div;
    int i;
    wb(1'b1, 8'h04, 32'h0000_0001);
    wb(1'b1, 8'h00, 32'h0000_0002);
    per(0);
    chk(n, 259);
    wb(1'b1, 8'h04, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_00FF);
    repeat (40) @(posedge clk);
    wb(1'b1, 8'h00, 32'h0000_0001);
    i = 0;
    while (tick !== 1'b1 && i < 300) begin
      @(posedge clk);
      i++;
    end
    chk(i < 4, 1'b1);
    per(0);
    chk(n, 2);
  endtask
  task t_legacy;
    wb(1'b1, 8'h08, 32'h0000_0008);
    wb(1'b1, 8'h04, 32'h0000_0003);
    wb(1'b0, 8'h04, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0003);
    per(0);
    chk(n, 4);
    wb(1'b1, 8'h08, 32'h0000_0000);
  endtask
  task t_async;
    wb(1'b1, 8'h00, 32'h0000_0001);
    per(1);
    chk(n, 32);
    wb(1'b1, 8'h08, 32'h0000_0002);
    per(1);
    chk(n, 16);
    chk(dbl, 1'b1);
    per(2);
    chk(n, 2);
  endtask
  task t_link;
    int i;
    wb(1'b1, 8'h00, 32'h0000_0003);
    for (int d = 0; d < 2; d++) begin
      for (int e = 0; e < 2; e++) begin
        pen <= (d == 0);
        wb(1'b1, 8'h08, 32'h0000_0006 | (d << 4) | e);
        per(1);
        chk(n, d ? 8 : 24);
        chk(smode, 1'b1);
        chk(sck_oe, d);
        i = 0;
        while (pin !== 1'b0 && i < 60) begin
          @(posedge clk);
          i++;
        end
        while (pin !== 1'b1 && i < 60) begin
          @(posedge clk);
          i++;
        end
        while (txs !== 1'b1 && rxs !== 1'b1 && i < 60) begin
          @(posedge clk);
          i++;
        end
        if (i >= 60) tmo;
        chk(txs, e == 0);
        chk(rxs, e == 1);
      end
    end
    pen <= 1'b0;
    wb(1'b1, 8'h08, 32'h0000_0000);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, sel, dat, pen} = '0;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_div;
    t_legacy;
    t_async;
    t_link;
    give_verdict;
  end
endmodule
bind usart_baud_clock usart_baud_clock_monitor mon (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
  .ACK_O(ACK_O), .ERR_O(ERR_O), .SYNC_SERIAL_CLOCK_O(SYNC_SERIAL_CLOCK_O),
  .SYNC_SERIAL_CLOCK_OE_O(SYNC_SERIAL_CLOCK_OE_O),
  .BAUD_TICK_O(BAUD_TICK_O), .TX_SHIFT_O(TX_SHIFT_O),
  .RX_SAMPLE_O(RX_SAMPLE_O), .SYNC_MODE_O(SYNC_MODE_O),
  .DOUBLE_SPEED_O(DOUBLE_SPEED_O)
);
